// File: include/wdt_pkg.sv
// Constants shared by the watchdog core and its count-clock selector.
// Assumes a single 25 MHz system clock and byte-wide registers on a word bus.
package wdt_pkg;
  // Register byte addresses on the bus
  localparam logic [7:0] OFF_COUNTER = 8'h00;
  localparam logic [7:0] OFF_MODE = 8'h04;
  localparam logic [7:0] OFF_CTRL = 8'h08;
  localparam logic [7:0] OFF_CLK_STOP = 8'h0c;
  localparam logic [7:0] OFF_PORT_MODE = 8'h10;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h14;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h18;
  // Reset values
  localparam logic [7:0] COUNTER_RST = 8'h00;
  localparam logic [3:0] CKS_RST = 4'hf;
  localparam logic [3:0] MODE_HI_READ = 4'hf;
  localparam logic [7:0] CLK_STOP_READ = 8'hfb;
  localparam logic [7:0] PORT_MODE_READ = 8'hd8;
  // Field positions
  localparam int STBY_BIT = 2;
  localparam int SRC_BIT = 2;
  localparam int WE_BIT = 0;
  localparam int INH_BIT = 1;
  localparam int WATCHDOG_ON_BIT_BIT = 2;
  localparam int WATCHDOG_RESET_FLAG_BIT = 3;
  localparam int OVF_IRQ_BIT = 0;
  localparam int CKS_OSC_BIT = 3;
  // Counter limits
  localparam logic [7:0] COUNTER_MAX = 8'hff;
  // Count-clock dividers
  localparam int PRESCALE_W = 13;
  localparam int DIV_BASE_LOG2 = 6;
  localparam logic [4:0] WATCH_DIV_LAST = 5'h1f;
  // Internal reset length in oscillator cycles
  localparam logic [9:0] RESET_HOLD = 10'h200;
endpackage

// File: include/wdt_tick_if.sv
// Link between the watchdog core and its count-clock selector.
// Both ends share clk_in; no crossing happens here.
`timescale 1ns/100ps
interface wdt_tick_if;
  logic [3:0] cks; // Clock-select field
  logic src_sel; // 1 picks watch clock / 32
  logic count_tick; // One-cycle count pulse
  modport core (output cks, output src_sel, input count_tick);
  modport gen (input cks, input src_sel, output count_tick);
endinterface

// File: design/wdt_tick_gen.sv
// Count-clock selector: prescaled base clock, watch clock / 32 or oscillator.
// Assumes the oscillator and watch clock arrive as one-cycle synchronous ticks.
`timescale 1ns/100ps
module wdt_tick_gen (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic osc_tick_in,
  input wire logic watch_tick_in,
  wdt_tick_if.gen sel
);
  // All state of the selector
  typedef struct packed {
    logic [wdt_pkg::PRESCALE_W-1:0] pre; // Free-running base prescaler
    logic [4:0] wdiv; // Watch clock divider
    logic tick; // Registered count pulse
  } gen_state_t;

  gen_state_t s_q;
  gen_state_t s_d;
  logic [wdt_pkg::PRESCALE_W-1:0] mask; // Low bits that must be all ones

  assign sel.count_tick = s_q.tick;

  ////////////////////////////////////////////////////////////////////////////
  // Next state: a divide by 2^k ticks when the low k prescaler bits are ones
  always_comb begin
    s_d = s_q;
    mask = '0;
    s_d.pre = s_q.pre + 1'b1;
    s_d.tick = 1'b0;
    if (watch_tick_in) begin
      s_d.wdiv = s_q.wdiv + 1'b1;
    end
    if (sel.src_sel) begin
      // Watch clock over 32 overrides the select field
      s_d.tick = watch_tick_in && (s_q.wdiv == wdt_pkg::WATCH_DIV_LAST);
    end else if (sel.cks[wdt_pkg::CKS_OSC_BIT]) begin
      s_d.tick = osc_tick_in;
    end else begin
      // Codes 000..111 give 64..8192, so 110 is 4096 and 111 is 8192
      mask = wdt_pkg::PRESCALE_W'((1 << (wdt_pkg::DIV_BASE_LOG2 + sel.cks[2:0])) - 1);
      s_d.tick = ((s_q.pre & mask) == mask);
    end
  end

  // State register
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  a_div_4096_tick: assert property (
    (!sel.src_sel && sel.cks == 4'h6 && s_d.tick) |-> (s_q.pre[11:0] == 12'hfff))
    else $error("base/4096 tick off its prescaler phase");
  a_watch_div_tick: assert property (
    (sel.src_sel && s_d.tick) |-> (watch_tick_in && s_q.wdiv == 5'h1f))
    else $error("watch clock tick not divided by 32");
endmodule

// File: design/watchdog_timer_core.sv
// Watchdog timer core: 8-bit up-counter, control registers, AHB-Lite slave.
// Assumes one 25 MHz clock; oscillator and watch ticks and the low-power
// mode levels come in synchronous to clk_in.
//
// Operation
// - Codes 110/111 divide 4096/8192; 1xxx picks oscillator
// - Standby bit 0 stops module, 1 releases
// - Standby bit stored but ignored while watchdog on
// - Source bit 1 selects watch clock over 32
// - Start needs write-enable, inhibit 0, on 1
// - Watchdog on and counting right after reset
// - Overflow past FF; reset one cycle later
// - Internal reset held 512 oscillator cycles
// - Written value loads counter, counting continues upward
// - Sub modes run only from watch or oscillator
// - Standby runs only from oscillator; registers retained
// - Overflow also sets the watchdog reset flag
`timescale 1ns/100ps
module watchdog_timer_core (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  input wire logic osc_tick_in,
  input wire logic watch_tick_in,
  input wire logic sub_mode_in,
  input wire logic standby_mode_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  output logic internal_reset_out,
  output logic irq_out
);
  // All state of the core
  typedef struct packed {
    logic [7:0] counter; // wd_counter
    logic [3:0] cks; // Clock-select field of wd_clock_mode_reg
    logic write_en; // ctrl_write_enable_bit
    logic watchdog_on_bit; // watchdog_on_bit
    logic watchdog_reset_flag; // watchdog_reset_flag
    logic stby_ctrl; // wd_standby_ctrl, in module_clock_stop_two
    logic src_sel; // wd_source_select, in port_two_function_mode
    logic irq_stat; // Sticky overflow event
    logic irq_mask; // Overflow event enable
    logic ovf; // One-cycle overflow marker
    logic rst_out; // Internal chip reset
    logic [9:0] hold; // Oscillator cycles left in reset
    logic wr_pend; // Data phase of a write is due
    logic [7:0] wr_addr; // Address captured for that write
    logic [31:0] rdata; // Read data for the data phase
    logic irq; // Registered interrupt level
    logic bus_ready; // Registered slave ready, never lowered
    logic bus_err; // Registered error response, never raised
  } core_state_t;

  core_state_t s_q;
  core_state_t s_d;
  logic take; // Address phase accepted
  logic [7:0] addr; // Word address bits in use
  logic [7:0] wd; // Low byte of write data
  logic wr_cnt; // Write to the counter this cycle
  logic wr_ctrl; // Write to the control/status register
  logic mod_stby; // Module standby in force
  logic mode_ok; // Low-power mode lets the source run
  logic run; // Counter advances on this tick
  logic [31:0] rd_mux; // Read value at address phase

  wdt_tick_if tk ();

  // Count-clock selector
  wdt_tick_gen u_tick (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .osc_tick_in(osc_tick_in),
    .watch_tick_in(watch_tick_in),
    .sel(tk.gen)
  );

  assign tk.cks = s_q.cks;
  assign tk.src_sel = s_q.src_sel;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode and run conditions
  always_comb begin
    take = hsel_in && htrans_in[1] && hready_in;
    addr = {haddr_in[7:2], 2'b00};
    wd = hwdata_in[7:0];
    wr_cnt = s_q.wr_pend && (s_q.wr_addr == wdt_pkg::OFF_COUNTER);
    wr_ctrl = s_q.wr_pend && (s_q.wr_addr == wdt_pkg::OFF_CTRL);
    // A cleared standby bit only bites once the watchdog is off
    mod_stby = !s_q.stby_ctrl && !s_q.watchdog_on_bit;
    mode_ok = 1'b1;
    if (standby_mode_in) begin
      // Only the oscillator keeps going in standby
      mode_ok = !s_q.src_sel && s_q.cks[wdt_pkg::CKS_OSC_BIT];
    end else if (sub_mode_in) begin
      // Base clock is stopped in sub modes
      mode_ok = s_q.src_sel || s_q.cks[wdt_pkg::CKS_OSC_BIT];
    end
    run = tk.count_tick && s_q.watchdog_on_bit && !mod_stby && mode_ok;
  end

  // Read multiplexer, sampled in the address phase
  always_comb begin
    rd_mux = '0;
    if (addr == wdt_pkg::OFF_COUNTER) begin
      rd_mux[7:0] = s_q.counter;
    end else if (addr == wdt_pkg::OFF_MODE) begin
      // Upper nibble is reserved and reads as ones
      rd_mux[7:0] = {wdt_pkg::MODE_HI_READ, s_q.cks};
    end else if (addr == wdt_pkg::OFF_CTRL) begin
      // Write-inhibit bit always reads as one
      rd_mux[wdt_pkg::WE_BIT] = s_q.write_en;
      rd_mux[wdt_pkg::INH_BIT] = 1'b1;
      rd_mux[wdt_pkg::WATCHDOG_ON_BIT_BIT] = s_q.watchdog_on_bit;
      rd_mux[wdt_pkg::WATCHDOG_RESET_FLAG_BIT] = s_q.watchdog_reset_flag;
    end else if (addr == wdt_pkg::OFF_CLK_STOP) begin
      // Other modules' stop bits are not ours and read as their reset ones
      rd_mux[7:0] = wdt_pkg::CLK_STOP_READ;
      rd_mux[wdt_pkg::STBY_BIT] = s_q.stby_ctrl;
    end else if (addr == wdt_pkg::OFF_PORT_MODE) begin
      rd_mux[7:0] = wdt_pkg::PORT_MODE_READ;
      rd_mux[wdt_pkg::SRC_BIT] = s_q.src_sel;
    end else if (addr == wdt_pkg::OFF_IRQ_STAT) begin
      rd_mux[wdt_pkg::OVF_IRQ_BIT] = s_q.irq_stat;
    end else if (addr == wdt_pkg::OFF_IRQ_MASK) begin
      rd_mux[wdt_pkg::OVF_IRQ_BIT] = s_q.irq_mask;
    end else begin
      // Unmapped words read as zero
      rd_mux = '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    s_d = s_q;
    s_d.ovf = 1'b0;
    // Bus: capture address phase, answer with no wait state
    s_d.wr_pend = take && hwrite_in;
    if (take) begin
      s_d.wr_addr = addr;
    end
    if (take && !hwrite_in) begin
      s_d.rdata = rd_mux;
    end

    // Counter: a software load beats a count on the same cycle
    if (wr_cnt && !mod_stby) begin
      s_d.counter = wd;
    end else if (run) begin
      s_d.counter = s_q.counter + 1'b1;
      if (s_q.counter == wdt_pkg::COUNTER_MAX) begin
        s_d.ovf = 1'b1;
      end
    end

    // Register writes; mode and control are frozen in module standby
    if (s_q.wr_pend && !mod_stby && s_q.wr_addr == wdt_pkg::OFF_MODE) begin
      s_d.cks = wd[3:0];
    end
    if (wr_ctrl && !mod_stby) begin
      s_d.write_en = wd[wdt_pkg::WE_BIT];
      // Watchdog on only changes with write-enable already set and inhibit low
      if (s_q.write_en && !wd[wdt_pkg::INH_BIT]) begin
        s_d.watchdog_on_bit = wd[wdt_pkg::WATCHDOG_ON_BIT_BIT];
      end
      // Software may clear the flag by writing zero
      if (!wd[wdt_pkg::WATCHDOG_RESET_FLAG_BIT]) begin
        s_d.watchdog_reset_flag = 1'b0;
      end
    end
    if (s_q.wr_pend && s_q.wr_addr == wdt_pkg::OFF_CLK_STOP) begin
      s_d.stby_ctrl = wd[wdt_pkg::STBY_BIT];
    end
    if (s_q.wr_pend && s_q.wr_addr == wdt_pkg::OFF_PORT_MODE) begin
      s_d.src_sel = wd[wdt_pkg::SRC_BIT];
    end
    if (s_q.wr_pend && s_q.wr_addr == wdt_pkg::OFF_IRQ_STAT) begin
      // Write one to clear
      if (wd[wdt_pkg::OVF_IRQ_BIT]) begin
        s_d.irq_stat = 1'b0;
      end
    end
    if (s_q.wr_pend && s_q.wr_addr == wdt_pkg::OFF_IRQ_MASK) begin
      s_d.irq_mask = wd[wdt_pkg::OVF_IRQ_BIT];
    end

    // Overflow events; set wins over a clear in the same cycle
    if (s_d.ovf) begin
      s_d.watchdog_reset_flag = 1'b1;
      s_d.irq_stat = 1'b1;
    end

    // Internal reset starts one cycle after overflow, then counts oscillator
    if (s_q.ovf) begin
      s_d.rst_out = 1'b1;
      s_d.hold = wdt_pkg::RESET_HOLD;
    end else if (s_q.rst_out && osc_tick_in) begin
      s_d.hold = s_q.hold - 1'b1;
      if (s_q.hold == 10'h001) begin
        s_d.rst_out = 1'b0;
      end
    end

    s_d.irq = s_d.irq_stat && s_d.irq_mask;
  end

  // State register; the watchdog comes up already on
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      s_q <= '0;
      s_q.counter <= wdt_pkg::COUNTER_RST;
      s_q.cks <= wdt_pkg::CKS_RST;
      s_q.watchdog_on_bit <= 1'b1;
      s_q.stby_ctrl <= 1'b1;
      s_q.bus_ready <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flip-flops; always zero wait and OKAY
  // Ready and response sit in flops too, so no output is a bare tie-off
  assign hrdata_out = s_q.rdata;
  assign hreadyout_out = s_q.bus_ready;
  assign hresp_out = s_q.bus_err;
  assign internal_reset_out = s_q.rst_out;
  assign irq_out = s_q.irq;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  a_ovf_to_reset: assert property (
    $rose(s_q.ovf) |-> (s_q.counter == 8'h00) ##1 s_q.rst_out)
    else $error("internal reset not one cycle after overflow");
  a_reset_hold_len: assert property (
    $rose(s_q.rst_out) |-> (s_q.hold == 10'h200))
    else $error("reset hold not loaded with 512");
  a_reset_stays: assert property (
    (s_q.rst_out && s_q.hold > 10'h001) |=> s_q.rst_out)
    else $error("internal reset dropped early");
  a_ovf_sets_flag: assert property (
    s_q.ovf |-> s_q.watchdog_reset_flag && s_q.irq_stat)
    else $error("overflow did not set the reset flag");
  a_on_after_reset: assert property (
    $fell(reset_in) |-> s_q.watchdog_on_bit)
    else $error("watchdog not on after reset");
  a_start_guarded: assert property (
    (wr_ctrl && !s_q.write_en) |=> $stable(s_q.watchdog_on_bit))
    else $error("watchdog on changed without write enable");
  a_standby_kept: assert property (
    (s_q.watchdog_on_bit && !s_q.stby_ctrl && tk.count_tick && mode_ok && !wr_cnt) |=>
      (s_q.counter == $past(s_q.counter) + 8'h01))
    else $error("counter stopped while watchdog on");
  a_mstby_halts: assert property (
    (mod_stby && tk.count_tick) |=> $stable(s_q.counter) && $stable(s_q.cks))
    else $error("counter moved in module standby");
  a_sub_halts: assert property (
    (sub_mode_in && !standby_mode_in && !s_q.src_sel && !s_q.cks[3] && !wr_cnt) |=>
      $stable(s_q.counter))
    else $error("counter ran from base clock in sub mode");
  a_stby_halts: assert property (
    (standby_mode_in && (s_q.src_sel || !s_q.cks[3]) && !wr_cnt) |=> $stable(s_q.counter))
    else $error("counter ran in standby off the oscillator");
  a_load_value: assert property (
    (wr_cnt && !mod_stby) |=> (s_q.counter == $past(hwdata_in[7:0])))
    else $error("counter write not loaded");
endmodule

// File: dv/test_watchdog_timer_core.sv
// Self-checking bench for the watchdog core: bus, counting, overflow, modes.
// Assumes the core answers with zero wait states and one 25 MHz clock.
`timescale 1ns/100ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin err_total++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module test_watchdog_timer_core;
  logic clk_in, reset_in, hsel_in, hwrite_in, osc_tick_in, watch_tick_in;
  logic sub_mode_in, standby_mode_in, hreadyout_out, hresp_out;
  logic internal_reset_out, irq_out;
  logic [1:0] htrans_in;
  logic [31:0] haddr_in, hwdata_in, hrdata_out, rd;
  int err_total = 0;
  int compares = 0;
  // Bus ready is the single slave's own ready
  watchdog_timer_core watchdog_timer_core_i (.clk_in(clk_in), .reset_in(reset_in),
    .hsel_in(hsel_in), .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in),
    .hsize_in(3'h2), .hwdata_in(hwdata_in), .hready_in(hreadyout_out),
    .osc_tick_in(osc_tick_in), .watch_tick_in(watch_tick_in), .sub_mode_in(sub_mode_in),
    .standby_mode_in(standby_mode_in), .hrdata_out(hrdata_out),
    .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
    .internal_reset_out(internal_reset_out), .irq_out(irq_out));
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Closing report, reached from the end of the run or from a timeout
  task automatic wrap_up();
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Waits for ready at a rising edge; bounded so a stuck slave ends the run
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (hreadyout_out !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_total++;
      wrap_up();
    end
  endtask
  // One single word transfer; entered just after a rising edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel_in <= 1'b1;
    haddr_in <= {24'h000000, a};
    htrans_in <= 2'h2;
    hwrite_in <= wr;
    wait_ready();
    htrans_in <= 2'h0;
    hwdata_in <= wd;
    wait_ready();
    rd = hrdata_out;
  endtask
  // Oscillator or watch ticks, one cycle high then one low
  task automatic ticks(input logic watch, input int n);
    repeat (n) begin
      if (watch) watch_tick_in <= 1'b1;
      else osc_tick_in <= 1'b1;
      @(posedge clk_in);
      watch_tick_in <= 1'b0;
      osc_tick_in <= 1'b0;
      @(posedge clk_in);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Reset values, unmapped place, oscillator counting straight after reset
  task automatic sc_reset();
    bus(1'b0, wdt_pkg::OFF_MODE, 32'h0); `CHK(rd, 32'h000000ff)
    bus(1'b0, wdt_pkg::OFF_CTRL, 32'h0); `CHK(rd, 32'h00000006)
    bus(1'b0, wdt_pkg::OFF_CLK_STOP, 32'h0); `CHK(rd, 32'h000000ff)
    bus(1'b0, wdt_pkg::OFF_PORT_MODE, 32'h0); `CHK(rd, 32'h000000d8)
    bus(1'b0, 8'h1c, 32'h0); `CHK(rd, 32'h00000000)
    ticks(1'b0, 3);
    bus(1'b0, wdt_pkg::OFF_COUNTER, 32'h0); `CHK(rd, 32'h00000003)
  endtask
  // Overflow from a loaded value, flag, interrupt, reset length
  task automatic sc_overflow();
    int k;
    bus(1'b1, wdt_pkg::OFF_IRQ_MASK, 32'h1);
    bus(1'b1, wdt_pkg::OFF_COUNTER, 32'hfe);
    ticks(1'b0, 1);
    `CHK(internal_reset_out, 1'b0)
    bus(1'b0, wdt_pkg::OFF_COUNTER, 32'h0); `CHK(rd, 32'h000000ff)
    ticks(1'b0, 1);
    // Overflow edge has just passed; the reset follows one cycle later
    @(posedge clk_in);
    `CHK(internal_reset_out, 1'b0)
    @(posedge clk_in);
    `CHK(internal_reset_out, 1'b1)
    `CHK(irq_out, 1'b1)
    // Slow source so no second overflow lands inside the reset pulse
    bus(1'b1, wdt_pkg::OFF_MODE, 32'h07);
    bus(1'b0, wdt_pkg::OFF_CTRL, 32'h0); `CHK(rd[3], 1'b1)
    bus(1'b1, wdt_pkg::OFF_CTRL, 32'h06);
    bus(1'b0, wdt_pkg::OFF_CTRL, 32'h0); `CHK(rd[3], 1'b0)
    bus(1'b1, wdt_pkg::OFF_IRQ_MASK, 32'h0);
    @(posedge clk_in);
    `CHK(irq_out, 1'b0)
    bus(1'b1, wdt_pkg::OFF_IRQ_STAT, 32'h1);
    bus(1'b0, wdt_pkg::OFF_IRQ_STAT, 32'h0); `CHK(rd, 32'h00000000)
    k = 0;
    while (internal_reset_out === 1'b1 && k < 600) begin
      ticks(1'b0, 1);
      k++;
    end
    `CHK(k, 512)
    // A reset that never ends stops the run here
    if (k >= 600) begin
      wrap_up();
    end
  endtask
  // Cycles between two increments under a prescaled base clock
  task automatic sc_divide(input logic [7:0] code, input int div);
    int c, t0;
    logic [7:0] v;
    bus(1'b1, wdt_pkg::OFF_MODE, {24'h0, code});
    bus(1'b0, wdt_pkg::OFF_COUNTER, 32'h0);
    v = rd[7:0];
    c = 0;
    t0 = 0;
    for (int i = 0; i < 2; i++) begin
      while (rd[7:0] === v && c < 20000) begin
        bus(1'b0, wdt_pkg::OFF_COUNTER, 32'h0);
        c += 2;
      end
      v = rd[7:0];
      if (i == 0) t0 = c;
    end
    `CHK(((c - t0) >= div - 2) && ((c - t0) <= div + 2), 1'b1)
    // A source that never ticks ends the run here
    if (c >= 20000) begin
      err_total++;
      wrap_up();
    end
  endtask
  // Watch clock over 32, then sub and standby gating
  task automatic sc_modes();
    bus(1'b1, wdt_pkg::OFF_MODE, 32'h08);
    bus(1'b1, wdt_pkg::OFF_PORT_MODE, 32'h04);
    bus(1'b1, wdt_pkg::OFF_COUNTER, 32'h10);
    ticks(1'b0, 4);
    ticks(1'b1, 64);
    bus(1'b0, wdt_pkg::OFF_COUNTER, 32'h0); `CHK(rd, 32'h00000012)
    bus(1'b1, wdt_pkg::OFF_PORT_MODE, 32'h00);
    bus(1'b1, wdt_pkg::OFF_MODE, 32'h00);
    bus(1'b1, wdt_pkg::OFF_COUNTER, 32'h20);
    sub_mode_in <= 1'b1;
    repeat (300) @(posedge clk_in);
    bus(1'b0, wdt_pkg::OFF_COUNTER, 32'h0); `CHK(rd, 32'h00000020)
    bus(1'b1, wdt_pkg::OFF_MODE, 32'h08);
    ticks(1'b0, 2);
    bus(1'b0, wdt_pkg::OFF_COUNTER, 32'h0); `CHK(rd, 32'h00000022)
    standby_mode_in <= 1'b1;
    ticks(1'b0, 1);
    bus(1'b1, wdt_pkg::OFF_PORT_MODE, 32'h04);
    ticks(1'b1, 32);
    bus(1'b0, wdt_pkg::OFF_COUNTER, 32'h0); `CHK(rd, 32'h00000023)
    bus(1'b0, wdt_pkg::OFF_MODE, 32'h0); `CHK(rd, 32'h000000f8)
    standby_mode_in <= 1'b0;
    sub_mode_in <= 1'b0;
    bus(1'b1, wdt_pkg::OFF_PORT_MODE, 32'h00);
  endtask
  // Standby bit while running, stop, module standby, two-write start
  task automatic sc_standby();
    bus(1'b1, wdt_pkg::OFF_COUNTER, 32'h40);
    bus(1'b1, wdt_pkg::OFF_CLK_STOP, 32'h00);
    bus(1'b0, wdt_pkg::OFF_CLK_STOP, 32'h0); `CHK(rd, 32'h000000fb)
    ticks(1'b0, 1);
    bus(1'b0, wdt_pkg::OFF_COUNTER, 32'h0); `CHK(rd, 32'h00000041)
    bus(1'b1, wdt_pkg::OFF_CTRL, 32'h01);
    bus(1'b1, wdt_pkg::OFF_CTRL, 32'h01);
    ticks(1'b0, 2);
    bus(1'b1, wdt_pkg::OFF_COUNTER, 32'h55);
    bus(1'b0, wdt_pkg::OFF_COUNTER, 32'h0); `CHK(rd, 32'h00000041)
    bus(1'b1, wdt_pkg::OFF_CLK_STOP, 32'h04);
    bus(1'b1, wdt_pkg::OFF_CTRL, 32'h01);
    bus(1'b1, wdt_pkg::OFF_CTRL, 32'h07);
    bus(1'b0, wdt_pkg::OFF_CTRL, 32'h0); `CHK(rd[2], 1'b0)
    bus(1'b1, wdt_pkg::OFF_CTRL, 32'h05);
    bus(1'b0, wdt_pkg::OFF_CTRL, 32'h0); `CHK(rd[2], 1'b1)
    ticks(1'b0, 1);
    bus(1'b0, wdt_pkg::OFF_COUNTER, 32'h0); `CHK(rd, 32'h00000042)
  endtask
  // Mid-run chip reset brings the counter and both registers back
  task automatic sc_rerun();
    reset_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    reset_in <= 1'b0;
    bus(1'b0, wdt_pkg::OFF_COUNTER, 32'h0); `CHK(rd, 32'h00000000)
    bus(1'b0, wdt_pkg::OFF_MODE, 32'h0); `CHK(rd, 32'h000000ff)
    bus(1'b0, wdt_pkg::OFF_CTRL, 32'h0); `CHK(rd, 32'h00000006)
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    reset_in = 1'b1;
    hsel_in = 1'b0;
    haddr_in = 32'h0;
    htrans_in = 2'h0;
    hwrite_in = 1'b0;
    hwdata_in = 32'h0;
    osc_tick_in = 1'b0;
    watch_tick_in = 1'b0;
    sub_mode_in = 1'b0;
    standby_mode_in = 1'b0;
    repeat (6) @(posedge clk_in);
    reset_in <= 1'b0;
    `CHK(hresp_out, 1'b0)
    `CHK(hreadyout_out, 1'b1)
    sc_reset();
    sc_overflow();
    sc_divide(8'h06, 4096);
    sc_divide(8'h07, 8192);
    sc_modes();
    sc_standby();
    sc_rerun();
    wrap_up();
  end
endmodule
